// ==== hw/spc_top.sv ====
// Serial port clock selection, transmit stop and DMA/interrupt routing
`timescale 1ns/100ps
`default_nettype none
`include "spc_defs.svh"

module spc_top
	import spc_pkg::*;
#(
	parameter int DEPTH = 16
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	output logic             txd,
	input  wire logic        rxd,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             err_irq,
	output logic             tx_dma_req,
	output logic             rx_dma_req
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] ctrl_q;
	logic [7:0]  mode_q;
	logic [15:0] stopcnt_q;
	logic [7:0]  txtrig_q;
	logic [15:0] baud_q;
	logic [6:0]  stat_q;
	logic [15:0] sent_q;
	logic [7:0]  dma_wr_q;
	logic [7:0]  fifo_q [DEPTH];
	logic [$clog2(DEPTH):0]   cnt_q;
	logic [$clog2(DEPTH)-1:0] rd_q;
	logic [$clog2(DEPTH)-1:0] wr_q;
	logic [7:0]  rxbuf_q;

	logic [1:0] cke;
	logic       sync_mode;
	logic       wr_en;
	logic       tx_low;
	logic       fifo_push;
	logic       tick;
	logic       sck_edge;
	logic       fifo_full;
	logic       stop_hit;
	logic       cke_bad;

	assign cke       = ctrl_q[`SPC_CTRL_CKE_LO +: 2];
	assign sync_mode = mode_q[`SPC_MODE_SYNC];
	assign wr_en     = psel && penable && pwrite;
	assign tx_low    = (32'(cnt_q) <= 32'(txtrig_q));
	assign fifo_push = wr_en && (paddr == `SPC_OFF_TXDATA) && !fifo_full;
	assign fifo_full  = (cnt_q == ($clog2(DEPTH)+1)'(DEPTH));
	assign stop_hit   = (stopcnt_q != 16'h0000) && (sent_q == stopcnt_q);
	// Prohibited codes flagged for software
	assign cke_bad = sync_mode ? (cke == `SPC_CKE_INT || cke == 2'b11) : cke[0];

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= `SPC_CTRL_RESET;
			mode_q    <= `SPC_MODE_RESET;
			stopcnt_q <= 16'h0000;
			txtrig_q  <= `SPC_TXTRIG_RESET;
			baud_q    <= `SPC_BAUD_RESET;
		end else if (wr_en) begin
			case (paddr)
				`SPC_OFF_CTRL:    ctrl_q    <= pwdata[15:0];
				`SPC_OFF_MODE:    mode_q    <= pwdata[7:0];
				`SPC_OFF_STOPCNT: stopcnt_q <= pwdata[15:0];
				`SPC_OFF_TXTRIG:  txtrig_q  <= pwdata[7:0];
				`SPC_OFF_BAUD:    baud_q    <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
					`SPC_OFF_CTRL:    prdata <= {16'h0000, ctrl_q};
					`SPC_OFF_MODE:    prdata <= {24'h000000, mode_q};
					`SPC_OFF_STOPCNT: prdata <= {16'h0000, stopcnt_q};
					`SPC_OFF_TXTRIG:  prdata <= {24'h000000, txtrig_q};
					`SPC_OFF_STATUS:  prdata <= {25'h0, stat_q};
					`SPC_OFF_TXDATA:  prdata <= 32'h0000_0000;
					`SPC_OFF_RXDATA:  prdata <= {24'h000000, rxbuf_q};
					`SPC_OFF_BAUD:    prdata <= {16'h0000, baud_q};
					default:          pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Link pin synchronisers
	// ----------------------------------------
	logic [1:0] sck_sync_q;
	logic [1:0] rxd_sync_q;
	logic       sck_prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_sync_q <= 2'b11;
			rxd_sync_q <= 2'b11;
			sck_prev_q <= 1'b1;
		end else begin
			sck_sync_q <= {sck_sync_q[0], sck_in};
			rxd_sync_q <= {rxd_sync_q[0], rxd};
			sck_prev_q <= sck_sync_q[1];
		end
	end

	// ----------------------------------------
	// Clock source and bit timing
	// ----------------------------------------
	logic [15:0] baud_cnt_q;
	logic [4:0]  ext_cnt_q;
	logic        sck_rise;
	assign sck_rise = sck_sync_q[1] && !sck_prev_q;

	// Internal generator wraps once per bit in async mode and once per half bit in sync output mode; pin input ignored on 00
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			baud_cnt_q <= 16'h0000;
		else if (baud_cnt_q >= baud_q - 16'h0001)
			baud_cnt_q <= 16'h0000;
		else
			baud_cnt_q <= baud_cnt_q + 16'h0001;
	end

	// External async clock: both pin edges sampled, 16 edges (8 periods) per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_cnt_q <= 5'd0;
		else if (sck_edge)
			ext_cnt_q <= (ext_cnt_q == `SPC_EXT_DIV - 5'd1) ? 5'd0 : ext_cnt_q + 5'd1;
	end

	always_comb begin
		tick = 1'b0;
		case ({sync_mode, cke})
			{1'b0, `SPC_CKE_INT}: tick = (baud_cnt_q == 16'h0000);
			{1'b0, `SPC_CKE_EXT}: tick = sck_edge && (ext_cnt_q == 5'd0);
			{1'b1, `SPC_CKE_OUT}: tick = (baud_cnt_q == 16'h0000) && sck_out;
			{1'b1, `SPC_CKE_EXT}: tick = sck_rise;
			default:              tick = 1'b0;
		endcase
	end
	assign sck_edge = sck_sync_q[1] != sck_prev_q;

	// Output clock toggles each half bit, one full period per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_out <= 1'b1;
			sck_oe  <= 1'b0;
		end else begin
			sck_oe <= sync_mode && (cke == `SPC_CKE_OUT);
			if (sync_mode && cke == `SPC_CKE_OUT && baud_cnt_q == 16'h0000)
				sck_out <= !sck_out;
			else if (!(sync_mode && cke == `SPC_CKE_OUT))
				sck_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// Transmit FIFO and shifter
	// ----------------------------------------
	spc_tx_state_t tx_st_q;
	logic [8:0]    shreg_q;
	logic [3:0]    bitn_q;
	logic          pop;
	assign pop = (tx_st_q == SPC_IDLE) && (cnt_q != '0) && mode_q[`SPC_MODE_TXEN] && !stop_hit;

	always_ff @(posedge pclk) begin
		if (fifo_push)
			fifo_q[wr_q] <= pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			rd_q  <= '0;
			wr_q  <= '0;
		end else begin
			if (fifo_push)
				wr_q <= wr_q + ($clog2(DEPTH))'(1);
			if (pop)
				rd_q <= rd_q + ($clog2(DEPTH))'(1);
			cnt_q <= cnt_q + {{$clog2(DEPTH){1'b0}}, fifo_push} - {{$clog2(DEPTH){1'b0}}, pop};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q <= SPC_IDLE;
			shreg_q <= 9'h1ff;
			bitn_q  <= 4'd0;
			txd     <= 1'b1;
			sent_q  <= 16'h0000;
		end else begin
			if (wr_en && paddr == `SPC_OFF_STOPCNT)
				sent_q <= 16'h0000;
			case (tx_st_q)
				SPC_IDLE: begin
					txd <= 1'b1;
					if (stop_hit)
						tx_st_q <= SPC_STOPPED;
					else if (pop) begin
						// Start bit waits for a tick so it lasts a whole bit
						shreg_q <= {fifo_q[rd_q], 1'b0};
						bitn_q  <= 4'd0;
						tx_st_q <= SPC_SHIFT;
					end
				end
				SPC_SHIFT: begin
					if (tick) begin
						txd     <= shreg_q[0];
						shreg_q <= {1'b1, shreg_q[8:1]};
						bitn_q  <= bitn_q + 4'd1;
						if (bitn_q == 4'd10) begin
							txd     <= 1'b1;
							sent_q  <= sent_q + 16'h0001;
							tx_st_q <= SPC_IDLE;
						end
					end
				end
				SPC_STOPPED: begin
					if (!stop_hit)
						tx_st_q <= SPC_IDLE;
				end
				default: tx_st_q <= SPC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Status flags: set wins over write-0 clear
	// ----------------------------------------
	logic rx_done;
	logic rx_err;
	assign rx_done = 1'b0;
	assign rx_err  = 1'b0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q  <= 7'h00;
			rxbuf_q <= 8'h00;
		end else begin
			if (wr_en && paddr == `SPC_OFF_STATUS)
				stat_q <= stat_q & pwdata[6:0];
			if (stop_hit && tx_st_q == SPC_IDLE)
				stat_q[`SPC_ST_TSF] <= 1'b1;
			stat_q[`SPC_ST_TX_FIFO_EMPTY_FLAG]  <= tx_low;
			stat_q[`SPC_ST_RDF]   <= 1'b0;
			stat_q[`SPC_ST_CKERR] <= cke_bad;
			if (!rxd_sync_q[1] && rx_done)
				stat_q[`SPC_ST_BRK] <= 1'b1;
			if (rx_err)
				stat_q[`SPC_ST_ER] <= 1'b1;
		end
	end

	// ----------------------------------------
	// DMA versus interrupt routing
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dma_wr_q <= 8'h00;
		else if (!tx_dma_req)
			dma_wr_q <= 8'h00;
		else if (fifo_push)
			dma_wr_q <= dma_wr_q + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq     <= 1'b0;
			rx_irq     <= 1'b0;
			err_irq    <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
		end else begin
			// DMA wins when both enables set; a withdrawn request rises again next cycle while tx_low still holds
			tx_dma_req <= tx_low && ctrl_q[`SPC_CTRL_TIE]
				&& ctrl_q[`SPC_CTRL_TX_DMA_REQUEST_ENABLE]
				&& !(tx_dma_req && fifo_push && dma_wr_q >= txtrig_q);
			rx_dma_req <= stat_q[`SPC_ST_RDF] && ctrl_q[`SPC_CTRL_RIE]
				&& ctrl_q[`SPC_CTRL_RX_DMA_REQUEST_ENABLE];
			tx_irq <= (stat_q[`SPC_ST_TX_FIFO_EMPTY_FLAG] && ctrl_q[`SPC_CTRL_TIE]
				&& !ctrl_q[`SPC_CTRL_TX_DMA_REQUEST_ENABLE])
				|| (stat_q[`SPC_ST_TSF] && ctrl_q[`SPC_CTRL_TX_STOP_IRQ_ENABLE]);
			rx_irq <= (stat_q[`SPC_ST_RDF] || stat_q[`SPC_ST_DR])
				&& ctrl_q[`SPC_CTRL_RIE] && !ctrl_q[`SPC_CTRL_RX_DMA_REQUEST_ENABLE];
			err_irq <= (stat_q[`SPC_ST_ER] || stat_q[`SPC_ST_BRK])
				&& ctrl_q[`SPC_CTRL_RIE];
		end
	end

endmodule
`default_nettype wire

// ==== hw/spc_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

`define SPC_OFF_CTRL      12'h000
`define SPC_OFF_MODE      12'h004
`define SPC_OFF_STOPCNT   12'h008
`define SPC_OFF_TXTRIG    12'h00c
`define SPC_OFF_STATUS    12'h010
`define SPC_OFF_TXDATA    12'h014
`define SPC_OFF_RXDATA    12'h018
`define SPC_OFF_BAUD      12'h01c

`define SPC_CTRL_CKE_LO   0
`define SPC_CTRL_TX_STOP_IRQ_ENABLE     2
`define SPC_CTRL_RX_DMA_REQUEST_ENABLE    3
`define SPC_CTRL_TX_DMA_REQUEST_ENABLE    4
`define SPC_CTRL_RIE      6
`define SPC_CTRL_TIE      7
`define SPC_CTRL_RESET    16'h0000
`define SPC_CKE_INT       2'b00
`define SPC_CKE_OUT       2'b01
`define SPC_CKE_EXT       2'b10

`define SPC_MODE_SYNC     0
`define SPC_MODE_TXEN     1
`define SPC_MODE_RESET    8'h00

`define SPC_ST_TSF        0
`define SPC_ST_TX_FIFO_EMPTY_FLAG       1
`define SPC_ST_RDF        2
`define SPC_ST_DR         3
`define SPC_ST_ER         4
`define SPC_ST_BRK        5
`define SPC_ST_CKERR      6

`define SPC_EXT_DIV       5'd16
`define SPC_BAUD_RESET    16'h0010
`define SPC_TXTRIG_RESET  8'h00

`endif

// ==== hw/spc_pkg.sv ====
// Types shared by the serial port control logic
`default_nettype none
package spc_pkg;
	typedef enum logic [1:0] {SPC_IDLE, SPC_SHIFT, SPC_STOPPED} spc_tx_state_t;
endpackage
`default_nettype wire

// ==== verification/spc_props.sv ====
// Port-level checks for the serial port control block
`timescale 1ns/100ps
`default_nettype none
module spc_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic rx_irq,
	input wire logic err_irq,
	input wire logic tx_dma_req,
	input wire logic rx_dma_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error outside access");
	chk_rx_excl: assert property (!(rx_dma_req && rx_irq))
		else $error("rx dma and irq together");
	chk_err_nodma: assert property ($rose(err_irq) |-> !$rose(rx_dma_req))
		else $error("error raised dma");
	// A drop needs a committed write a few edges back
	chk_dma_drop: assert property ($fell(tx_dma_req) |-> $past(psel) || $past(psel, 2) || $past(psel, 3))
		else $error("dma drop without write");
	chk_start_bit: assert property ($fell(txd) |=> !txd)
		else $error("start bit too short");
endmodule
bind spc_top spc_props spc_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .txd(txd), .rx_irq(rx_irq),
	.err_irq(err_irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
`default_nettype wire

// ==== verification/spc_remote.sv ====
// Remote serial receiver and link clock source
`timescale 1ns/100ps
`default_nettype none
module spc_remote #(
	parameter int BIT_CYC = 8
)(
	input  wire logic       pclk,
	input  wire logic       txd,
	input  wire logic       clk_on,
	output logic            sck_in,
	output logic            rxd,
	output logic            got,
	output logic      [7:0] byte_q
);
	initial begin
		sck_in = 1'b1;
		rxd = 1'b1;
		got = 1'b0;
		byte_q = 8'h00;
	end
	// Clock stands high unless a frame is wanted
	always #80 sck_in = clk_on ? ~sck_in : 1'b1;
	always begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge pclk);
			byte_q[i] <= txd;
		end
		repeat (BIT_CYC) @(posedge pclk);
		got <= 1'b1;
		@(posedge pclk);
		got <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== verification/spc_top_tb_top.sv ====
// Self-checking bench for the serial port control block
`timescale 1ns/100ps
`default_nettype none
`include "spc_defs.svh"
module spc_top_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, clk_on, got;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, sck_in, sck_out, sck_oe, txd, rxd;
	logic        tx_irq, rx_irq, err_irq, tx_dma_req, rx_dma_req;
	logic [7:0]  rx_byte, b;
	logic [32:0] e;
	logic [32:0] rq[$];
	logic [7:0]  bq[$];
	logic [3:0]  md[7] = '{4'h0, 4'h2, 4'h6, 4'hd, 4'h6, 4'h2, 4'h0};
	int          err_count, tests_run, n;
	spc_top spc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .txd(txd),
		.rxd(rxd), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq),
		.tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
	spc_remote #(.BIT_CYC(4)) spc_remote_i (.pclk(pclk), .txd(txd), .clk_on(clk_on),
		.sck_in(sck_in), .rxd(rxd), .got(got), .byte_q(rx_byte));
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;
	task automatic check(input string s, input logic [32:0] v, input logic [32:0] x);
		tests_run++;
		if (v !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, x, v);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		rq.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic send(input logic keep);
		b = 8'($urandom);
		if (keep) bq.push_back(b);
		apb(1'b1, `SPC_OFF_TXDATA, {24'h0, b});
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = rq.pop_front();
			if (e[32]) check("slverr", 33'(pslverr), 33'h1);
			else check("rdata", {pslverr, prdata}, e);
		end
		if (got === 1'b1) begin
			if (bq.size() == 0) check("extra byte", 33'h1, 33'h0);
			else check("byte", 33'(rx_byte), 33'(bq.pop_front()));
		end
	end
	initial begin
		#50000;
		err_count++;
		test_done();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, clk_on} = '0;
		err_count = 0;
		tests_run = 0;
		void'($urandom(32'h5bcd));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SPC_OFF_CTRL, 33'h0);
		rd(`SPC_OFF_BAUD, 33'h10);
		rd(12'h0f0, 33'h1_0000_0000);
		$display("test reset done");
		foreach (md[i]) begin
			clk_on <= md[i][1];
			apb(1'b1, `SPC_OFF_CTRL, 32'(md[i][1:0]));
			apb(1'b1, `SPC_OFF_MODE, 32'(md[i][2]));
			@(posedge pclk);
			check("sck_oe", 33'(sck_oe), 33'(md[i][3]));
		end
		$display("test clock source done");
		apb(1'b1, `SPC_OFF_BAUD, 32'h4);
		apb(1'b1, `SPC_OFF_TXTRIG, 32'h1);
		apb(1'b1, `SPC_OFF_CTRL, 32'h90);
		@(posedge pclk);
		check("dma on", 33'({tx_dma_req, tx_irq}), 33'h2);
		send(1'b1);
		send(1'b1);
		@(posedge pclk);
		check("dma off", 33'({tx_dma_req, rx_dma_req, err_irq}), 33'h0);
		$display("test dma done");
		clk_on <= 1'b1;
		apb(1'b1, `SPC_OFF_CTRL, 32'h4);
		send(1'b0);
		apb(1'b1, `SPC_OFF_STOPCNT, 32'h2);
		apb(1'b1, `SPC_OFF_MODE, 32'h2);
		n = 0;
		while (bq.size() != 0 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		repeat (40) @(posedge pclk);
		check("stop irq", 33'(tx_irq), 33'h1);
		rd(`SPC_OFF_STATUS, 33'h3);
		apb(1'b1, `SPC_OFF_CTRL, 32'h0);
		@(posedge pclk);
		check("stop irq off", 33'(tx_irq), 33'h0);
		repeat (300) @(posedge pclk);
		check("queued", 33'(bq.size()), 33'h0);
		$display("test stop done");
		test_done();
	end
endmodule
`default_nettype wire
